// File: shared/sdwl_pkg.sv
// Package of constants and carrier types for the serial DAC word loader
package sdwl_pkg;

  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BIT_CNT_W   = 5;
  localparam logic [4:0]  BITS_PER_WORD = 5'h10;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_PTR_W  = 4;

  // Latch reset value and the named offset-binary codes
  localparam logic [15:0] LATCH_RST   = 16'h0000;
  localparam logic [15:0] BIPOLAR_ZERO = 16'h8000;
  localparam logic [15:0] NEG_FULL     = 16'h0000;
  localparam logic [15:0] POS_FULL     = 16'hffff;

  // Output settle time after a strobe update
  localparam int unsigned SETTLE_NS    = 5000;
  localparam int unsigned CLK_NS       = 40;
  localparam int unsigned SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_W     = 8;

  // Pins from the host
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic sync_n;
    logic latch_load_n;
  } sdwl_pins_t;

  // Synchroniser contents after reset: serial clock idles low, the strobes idle high
  localparam sdwl_pins_t PINS_IDLE = '{sclk: 1'b0, sdata: 1'b0, sync_n: 1'b1, latch_load_n: 1'b1};

  // Word passed from the shifter to the latch
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } sdwl_word_t;

endpackage

// File: src/sdwl_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sdwl_fifo
  import sdwl_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned PTR_W = 4
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [PTR_W:0]              cnt;
  } sdwl_fifo_st_t;

  sdwl_fifo_st_t s_q;
  sdwl_fifo_st_t s_d;
  logic          push;
  logic          pop;

  assign in_ready_o  = (s_q.cnt != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr          = s_q.wr + PTR_W'(1);
    end
    if (pop)
    begin
      s_d.rd = s_q.rd + PTR_W'(1);
    end
    s_d.cnt = s_q.cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

// File: src/sdwl_top.sv
// Serial word loader: shifts 16-bit words in and moves them to the converter latch
//
// Notes on behaviour
// - The link is three host lines: serial clock, serial data and an active-low frame select.
// - Each frame carries one 16-bit word, each bit sampled on a falling serial clock edge.
// - A word reaches the latch either automatically when complete or under the latch-load strobe.
// - In strobe mode the host lowers latch-load after the word is complete and that low updates the latch.
// - Offset-binary codes map 8000 to zero, 0000 to negative and ffff to positive full scale.
// - Falling edges are counted from frame start; only 16 are taken and later pulses are ignored.
// - Latch-load low at frame start updates on the sixteenth edge, else on the latch-load falling edge.
`timescale 1ns/1ns
module sdwl_top
  import sdwl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial link pins
  input  wire logic        sclk_i,
  input  wire logic        serial_data_in_i,
  input  wire logic        sync_n_i,
  input  wire logic        latch_load_n_i,
  // Converter latch
  output logic [15:0]      latch_o,
  output logic             latch_upd_o,
  output logic             out_settled_o,
  output logic             auto_mode_o,
  // Code classification
  output logic             at_zero_o,
  output logic             at_neg_full_o,
  output logic             at_pos_full_o,
  // Status
  output logic             overflow_o
);

  typedef struct packed {
    sdwl_pins_t            p1;
    sdwl_pins_t            p2;
    sdwl_pins_t            p3;
    logic                  in_frame;
    logic                  auto_mode;
    logic [BIT_CNT_W-1:0]  cnt;
    logic [WORD_W-1:0]     shift;
    logic                  push;
    logic [WORD_W-1:0]     push_data;
    logic                  word_held;
    logic                  strobe_pend;
    logic [WORD_W-1:0]     latch;
    logic                  upd;
    logic [SETTLE_W-1:0]   settle;
    logic                  settled;
    logic                  zero;
    logic                  negf;
    logic                  posf;
    logic                  ovf;
  } sdwl_st_t;

  sdwl_st_t        s_q;
  sdwl_st_t        s_d;
  sdwl_pins_t      pins;
  logic            fifo_ready;
  logic            fifo_valid;
  logic [15:0]     fifo_data;
  logic            pop;
  logic            fall_sclk;
  logic            frame_start;
  logic            frame_end;
  logic            ll_fall;

  // Codes that the offset-binary bipolar range names
  function automatic logic [2:0] code_class(input logic [15:0] c);
    code_class = {c == POS_FULL, c == NEG_FULL, c == BIPOLAR_ZERO};
  endfunction

  assign pins.sclk         = sclk_i;
  assign pins.sdata        = serial_data_in_i;
  assign pins.sync_n       = sync_n_i;
  assign pins.latch_load_n = latch_load_n_i;

  // p1 is only read by p2; edges are found between p2 and p3
  assign fall_sclk   = s_q.p3.sclk && !s_q.p2.sclk;
  assign frame_start = s_q.p3.sync_n && !s_q.p2.sync_n;
  assign frame_end   = !s_q.p3.sync_n && s_q.p2.sync_n;
  assign ll_fall     = s_q.p3.latch_load_n && !s_q.p2.latch_load_n;

  // Auto mode drains at once; strobe mode waits for a latch-load fall
  assign pop = fifo_valid && (s_q.auto_mode || s_q.strobe_pend);

  sdwl_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (FIFO_PTR_W)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (s_q.push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (s_q.push_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data)
  );

  always_comb
  begin
    s_d      = s_q;
    s_d.p1   = pins;
    s_d.p2   = s_q.p1;
    s_d.p3   = s_q.p2;
    s_d.push = 1'b0;
    s_d.upd  = 1'b0;
    if (frame_start)
    begin
      s_d.in_frame  = 1'b1;
      s_d.cnt       = '0;
      s_d.auto_mode = !s_q.p2.latch_load_n;
    end
    else if (frame_end)
    begin
      s_d.in_frame = 1'b0;
    end
    // Only the first sixteen falling edges of a frame are taken
    if (s_q.in_frame && !frame_end && fall_sclk && s_q.cnt != BITS_PER_WORD)
    begin
      s_d.shift = {s_q.shift[WORD_W-2:0], s_q.p2.sdata};
      s_d.cnt   = s_q.cnt + BIT_CNT_W'(1);
      if (s_q.cnt == BITS_PER_WORD - 5'h01)
      begin
        // A full FIFO drops the word rather than stall a host that cannot wait
        if (fifo_ready)
        begin
          s_d.push      = 1'b1;
          s_d.push_data = {s_q.shift[WORD_W-2:0], s_q.p2.sdata};
          s_d.word_held = 1'b1;
        end
        else
        begin
          s_d.ovf = 1'b1;
        end
      end
    end
    if (pop)
    begin
      s_d.latch       = fifo_data;
      s_d.upd         = 1'b1;
      s_d.strobe_pend = 1'b0;
      // A word still on its way into the FIFO stays counted as held
      s_d.word_held   = s_q.push || s_d.push;
      s_d.settle      = s_q.auto_mode ? '0 : SETTLE_W'(SETTLE_CYC);
      s_d.settled     = s_q.auto_mode;
      {s_d.posf, s_d.negf, s_d.zero} = code_class(fifo_data);
    end
    else if (s_q.settle != '0)
    begin
      s_d.settle  = s_q.settle - SETTLE_W'(1);
      s_d.settled = (s_q.settle == SETTLE_W'(1));
    end
    // A strobe before any complete word updates nothing
    // Sits after the pop so that a new strobe wins over the clear of the old one
    if (ll_fall && !s_q.auto_mode && (s_q.word_held || fifo_valid))
    begin
      s_d.strobe_pend = 1'b1;
    end
    // Latch otherwise holds its last value
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q                <= '0;
      s_q.p1             <= PINS_IDLE;
      s_q.p2             <= PINS_IDLE;
      s_q.p3             <= PINS_IDLE;
      s_q.latch          <= LATCH_RST;
      s_q.settled        <= 1'b1;
      s_q.negf           <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign latch_o       = s_q.latch;
  assign latch_upd_o   = s_q.upd;
  assign out_settled_o = s_q.settled;
  assign auto_mode_o   = s_q.auto_mode;
  assign at_zero_o     = s_q.zero;
  assign at_neg_full_o = s_q.negf;
  assign at_pos_full_o = s_q.posf;
  assign overflow_o    = s_q.ovf;

endmodule

// File: test/sdwl_top_asserts.sv
// Port checks for the serial word loader
`timescale 1ns/1ns
module sdwl_top_asserts
  import sdwl_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Link pins
  input wire logic        sclk_i,
  input wire logic        sync_n_i,
  input wire logic        latch_load_n_i,
  // Converter side
  input wire logic [15:0] latch_o,
  input wire logic        latch_upd_o,
  input wire logic        out_settled_o,
  input wire logic        auto_mode_o,
  input wire logic        at_zero_o
);
  // Link clock idles low, so every fall seen here lies inside a frame
  logic [4:0] cnt_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      cnt_q <= 5'h00;
    else if ($fell(sync_n_i))
      cnt_q <= 5'h00;
    else if ($fell(sclk_i))
      cnt_q <= cnt_q + 5'h01;
  property p_auto; $fell(sclk_i) && !latch_load_n_i && cnt_q == 5'h0f |-> ##[2:12] latch_upd_o; endproperty
  a_auto: assert property (p_auto) else $error("auto update missing");
  property p_count; latch_upd_o && auto_mode_o |-> cnt_q >= 5'h10; endproperty
  a_count: assert property (p_count) else $error("update before word end");
  property p_strobe; $fell(latch_load_n_i) && sync_n_i && !auto_mode_o && cnt_q >= 5'h10 |-> ##[2:10] latch_upd_o;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe update missing");
  property p_cause; latch_upd_o && !auto_mode_o |-> !$past(latch_load_n_i, 2); endproperty
  a_cause: assert property (p_cause) else $error("update without strobe");
  property p_hold; $changed(latch_o) |-> latch_upd_o; endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_zero; $stable(latch_o) |-> at_zero_o == (latch_o == BIPOLAR_ZERO); endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_settle; latch_upd_o && !auto_mode_o |=> !out_settled_o[*8] ##[100:130] out_settled_o; endproperty
  a_settle: assert property (p_settle) else $error("settle time wrong");
  // Counts sampled low cycles of the settle flag, since a repetition cannot reach the full span
  logic [7:0] low_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      low_q <= 8'h00;
    else if (out_settled_o)
      low_q <= 8'h00;
    else
      low_q <= low_q + 8'h01;
  end
  property p_settle_len; $rose(out_settled_o) |-> low_q == 8'(SETTLE_CYC); endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle length wrong");
  property p_pulse; latch_upd_o |=> !latch_upd_o; endproperty
  a_pulse: assert property (p_pulse) else $error("update too long");
  c_auto: cover property (latch_upd_o && auto_mode_o);
  c_strobe: cover property (latch_upd_o && !auto_mode_o);
  c_short: cover property ($rose(sync_n_i) && cnt_q == 5'h0f);
endmodule
bind sdwl_top sdwl_top_asserts u_chk (.clk_i, .rst_i, .sclk_i, .sync_n_i, .latch_load_n_i, .latch_o, .latch_upd_o,
  .out_settled_o, .auto_mode_o, .at_zero_o);

// File: test/sdwl_host_model.sv
// Host model driving the link pins and latch-load
`timescale 1ns/1ns
module sdwl_host_model
(
  // Bench clock, aligns pin changes
  input  wire logic clk_i,
  // Pins into the loader
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      sync_n_o,
  output logic      latch_load_n_o
);
  initial
  begin
    sclk_o = 1'b0;  // Idles low
    sdata_o = 1'b0;
    sync_n_o = 1'b1;
    latch_load_n_o = 1'b1;
  end
  task automatic send_word(input logic [15:0] w, input int nbits);
    @(posedge clk_i) #2;
    sync_n_o = 1'b0;  // One low frame for both bytes
    for (int i = 0; i < nbits; i++)
    begin
      #160 sclk_o = 1'b1;
      sdata_o = i < 16 ? w[15 - i] : 1'($urandom);  // MSB first, steady at the fall
      #160 sclk_o = 1'b0;
    end
    #160 sync_n_o = 1'b1;
    sdata_o = ~sdata_o;  // Released line must not keep the last bit
  endtask
  task automatic set_load(input logic lvl);
    @(posedge clk_i) #2 latch_load_n_o = lvl;  // Low selects automatic update
  endtask
  task automatic strobe();
    @(posedge clk_i) #2 latch_load_n_o = 1'b0;
    #400 latch_load_n_o = 1'b1;  // High again before next frame
  endtask
endmodule

// File: test/sdwl_top_test.sv
// Self-checking bench for the serial word loader
`timescale 1ns/1ns
module sdwl_top_test;
  import sdwl_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sclk, sdata, sync_n, ld_n, upd, settled, auto, zero, negf, posf, ovf;
  logic [15:0] latch, w;
  logic [15:0] q [17];
  int          errors = 0;
  int          total_checks = 0;
  wire  [18:0] seen = {latch, zero, negf, posf};
  sdwl_host_model u_host (.clk_i, .sclk_o(sclk), .sdata_o(sdata), .sync_n_o(sync_n), .latch_load_n_o(ld_n));
  sdwl_top u_dut (.clk_i, .rst_i, .sclk_i(sclk), .serial_data_in_i(sdata), .sync_n_i(sync_n), .latch_load_n_i(ld_n),
    .latch_o(latch), .latch_upd_o(upd), .out_settled_o(settled), .auto_mode_o(auto), .at_zero_o(zero),
    .at_neg_full_o(negf), .at_pos_full_o(posf), .overflow_o(ovf));
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [18:0] expect_word(input logic [15:0] v);
    return {v, v == BIPOLAR_ZERO, v == NEG_FULL, v == POS_FULL};
  endfunction
  task automatic check(input string name, input logic [18:0] exp, input logic [18:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Waits out the 125-cycle settle so the next strobe starts clean
  task automatic xfer(input logic [15:0] v, input int nbits, input bit strobe);
    fork
      if (strobe)
        u_host.strobe();
      else
        u_host.send_word(v, nbits);
      for (int n = 0; upd !== 1'b1; n++)
      begin
        if (n == 400)
        begin
          check("latch_upd_o", 19'h1, {18'h0, upd});
          complete_run();
        end
        @(negedge clk_i);
      end
    join
    @(negedge clk_i);
    check("latch", expect_word(v), seen);
    check("out_settled_o", {18'h0, !strobe}, {18'h0, settled});
    check("auto_mode_o", {18'h0, !strobe}, {18'h0, auto});
    repeat (130) @(negedge clk_i);
  endtask
  initial
  begin
    void'($urandom(47678));
    #102 rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    u_host.strobe();
    repeat (12) @(negedge clk_i);
    check("latch", expect_word(LATCH_RST), seen);
    check("overflow_o", 19'h0, {18'h0, ovf});
    u_host.set_load(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      w = i == 0 ? BIPOLAR_ZERO : i == 1 ? NEG_FULL : i == 2 ? POS_FULL : 16'($urandom);
      xfer(w, 16 + i % 4, 1'b0);
    end
    u_host.send_word(~w, 15);
    u_host.set_load(1'b1);
    for (int i = 0; i < 17; i++)
    begin
      q[i] = 16'($urandom);
      u_host.send_word(q[i], 16);
    end
    repeat (12) @(negedge clk_i);
    check("latch", expect_word(w), seen);
    check("overflow_o", 19'h1, {18'h0, ovf});
    for (int i = 0; i < 16; i++)
      xfer(q[i], 16, 1'b1);
    complete_run();
  end
endmodule
